// >>> rtl/bcs_pkg.sv
// Shared constants and types of the battery charge sequencer
`default_nettype none
package bcs_pkg;
	// Charger states
	typedef enum logic [2:0] {
		BCS_DISABLE,
		BCS_PREQUAL,
		BCS_CHARGE,
		BCS_TOPOFF,
		BCS_DONE,
		BCS_FAULT,
		BCS_THM_HOLD
	} bcs_state_t;

	// Charge source selection
	typedef enum logic [1:0] {
		BCS_SRC_NONE,
		BCS_SRC_DC,
		BCS_SRC_USB
	} bcs_src_t;

	// Thermistor zone codes from the comparator bank
	localparam logic [1:0] THM_ZONE_NONE  = 2'h0; // Below 315 ohm
	localparam logic [1:0] THM_ZONE_HOT   = 2'h1; // 315 ohm to 3.94k
	localparam logic [1:0] THM_ZONE_OK    = 2'h2; // 3.94k to 28.3k
	localparam logic [1:0] THM_ZONE_COLD  = 2'h3; // Above 28.3k

	// Current command codes for the analog regulator
	localparam logic [2:0] CUR_OFF        = 3'h0;
	localparam logic [2:0] CUR_SET_FULL   = 3'h1; // Resistor set, 100 %
	localparam logic [2:0] CUR_SET_PREQ   = 3'h2; // 10 % of set current
	localparam logic [2:0] CUR_SET_TOPOFF = 3'h3; // 7.5 % of set current
	localparam logic [2:0] CUR_USB_95MA   = 3'h4;
	localparam logic [2:0] CUR_USB_475MA  = 3'h5;

	// Timer: oscillator ticks per state at the reference 68 nF capacitor
	localparam int        TIMER_W          = 24;
	localparam int        CAP_REF_NF       = 68;
	localparam int        CHARGE_MIN       = 334;
	localparam int        PREQ_TENTH_MIN   = 348; // 34.8 min in tenths
	localparam int        TICKS_PER_MIN    = 60;  // One oscillator tick per second
	localparam logic [TIMER_W-1:0] CHARGE_TICKS =
		TIMER_W'(CHARGE_MIN * TICKS_PER_MIN);
	localparam logic [TIMER_W-1:0] PREQ_TICKS   =
		TIMER_W'((PREQ_TENTH_MIN * TICKS_PER_MIN) / 10);
endpackage : bcs_pkg
`default_nettype wire

// >>> rtl/bcs_sync.sv
// Two-flop synchroniser for a bus of asynchronous levels
`default_nettype none
module bcs_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         ref_clk_i,
	input  wire logic         rst_i,
	// Levels
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// First stage feeds only the second stage
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
		end
	end

	assign sync_o = sync_ff;
endmodule : bcs_sync
`default_nettype wire

// >>> rtl/bcs_timer.sv
// Reloadable state timer counting oscillator ticks with freeze
`default_nettype none
module bcs_timer (
	// Clock and reset
	input  wire logic                        ref_clk_i,
	input  wire logic                        rst_i,
	// Control
	input  wire logic                        load_i,
	input  wire logic [bcs_pkg::TIMER_W-1:0] load_val_i,
	input  wire logic                        tick_i,
	input  wire logic                        hold_i,
	// Status
	output logic                             expired_o
);
	logic [bcs_pkg::TIMER_W-1:0] cnt_ff;
	wire                         at_zero = (cnt_ff == '0);

	// Load wins; a hold freezes the count where it stands
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_ff <= '0;
		end else if (load_i) begin
			cnt_ff <= load_val_i;
		end else if (tick_i && !hold_i && !at_zero) begin
			cnt_ff <= cnt_ff - 1'b1;
		end
	end

	assign expired_o = at_zero && !load_i;
endmodule : bcs_timer
`default_nettype wire

// >>> rtl/bcs_top.sv
// Battery charge sequencer: source select, charge states, timers and flags
// Operation
// - DC wins when both inputs valid
// - Input valid only inside window, overvoltage blocks
// - Enable low runs, high holds disabled
// - USB current 95mA or 475mA by select
// - USB charge current ignores set resistor
// - Prequal 10 percent, top-off 7.5 percent
// - Thermistor four zones, two block charging
// - Charge 334 min, prequal/top-off 34.8 min
// - Thermistor hold freezes state timer
// - Power good low while input valid
// - Charging flag low only in Charge and in a hold entered from Charge
// - Thermistor hold keeps charging flag level
// - Prequal or Charge timeout enters Fault
// - Fault latched until power or enable cycle
// - Start Disable, Prequal when valid and enabled
// - Prequal to Charge at 3V or more
// - Bad thermistor in Prequal/Charge holds
// - Charge to Top-off at 7.5 percent current
// - Top-off expiry enters Done, zero current
// - Done recharges below 4.05V
`default_nettype none
module bcs_top (
	// Clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	// Input supply comparators (in window, above 7.5V)
	input  wire logic       dc_in_window_i,
	input  wire logic       dc_over_volt_i,
	input  wire logic       usb_in_window_i,
	input  wire logic       usb_over_volt_i,
	// Pins
	input  wire logic       enable_n_i,
	input  wire logic       usb_current_select_i,
	// Battery comparators
	input  wire logic       bat_above_3v_i,
	input  wire logic       bat_below_4v05_i,
	input  wire logic       cur_below_topoff_i,
	input  wire logic [1:0] thermistor_zone_i,
	// Timing capacitor oscillator, one pulse per tick
	input  wire logic       timer_capacitor_tick_i,
	// Status flags, active low
	output logic            power_good_flag_n_o,
	output logic            charging_flag_n_o,
	output logic            fault_flag_n_o,
	// Regulator control
	output logic            src_dc_sel_o,
	output logic            src_usb_sel_o,
	output logic [2:0]      current_cmd_o,
	output logic [2:0]      state_o
);
	localparam int NSYNC = 12;

	// Synchronised copies of all outside levels
	logic [NSYNC-1:0] sync_w;
	bcs_sync #(.W(NSYNC)) u_sync (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.async_i   ({dc_in_window_i, dc_over_volt_i, usb_in_window_i, usb_over_volt_i,
		             enable_n_i, usb_current_select_i, bat_above_3v_i, bat_below_4v05_i,
		             cur_below_topoff_i, thermistor_zone_i, timer_capacitor_tick_i}),
		.sync_o    (sync_w)
	);

	wire       dc_win   = sync_w[11];
	wire       dc_ov    = sync_w[10];
	wire       usb_win  = sync_w[9];
	wire       usb_ov   = sync_w[8];
	wire       en_n     = sync_w[7];
	wire       usb_hi   = sync_w[6];
	wire       bat_3v   = sync_w[5];
	wire       bat_low  = sync_w[4];
	wire       cur_low  = sync_w[3];
	wire [1:0] thm_zone = sync_w[2:1];
	wire       tick_lvl = sync_w[0];

	// Oscillator tick edge, taken from the second stage only
	logic tick_d_ff;
	wire  tick_w = tick_lvl && !tick_d_ff;

	// Input validity and source priority
	wire dc_ok   = dc_win && !dc_ov;
	wire usb_ok  = usb_win && !usb_ov;
	wire pwr_ok  = dc_ok || usb_ok;
	wire use_dc  = dc_ok;
	wire use_usb = usb_ok && !dc_ok;

	// Thermistor zone decode
	function automatic logic thm_allows(input logic [1:0] zone);
		thm_allows = (zone == bcs_pkg::THM_ZONE_NONE) || (zone == bcs_pkg::THM_ZONE_OK);
	endfunction : thm_allows
	wire thm_ok = thm_allows(thm_zone);

	// State and flag registers
	bcs_pkg::bcs_state_t state_ff, nxt_state;
	bcs_pkg::bcs_state_t hold_ret_ff; // State to resume after thermistor hold
	logic                chg_n_ff, nxt_chg_n;
	logic                flt_n_ff, nxt_flt_n;
	logic                pok_n_ff;
	logic                dc_sel_ff, usb_sel_ff;
	logic [2:0]          cur_ff, nxt_cur;

	// Timer
	logic                          tmr_load;
	logic [bcs_pkg::TIMER_W-1:0]   tmr_val;
	logic                          tmr_exp;
	wire                           in_hold = (state_ff == bcs_pkg::BCS_THM_HOLD);

	bcs_timer u_timer (
		.ref_clk_i  (ref_clk_i),
		.rst_i      (rst_i),
		.load_i     (tmr_load),
		.load_val_i (tmr_val),
		.tick_i     (tick_w),
		.hold_i     (in_hold),
		.expired_o  (tmr_exp)
	);

	// Entry into a timed state from a different state reloads the timer;
	// returning from thermistor hold does not, so the count carries on
	wire entering = (nxt_state != state_ff) && (state_ff != bcs_pkg::BCS_THM_HOLD);
	assign tmr_load = entering && ((nxt_state == bcs_pkg::BCS_PREQUAL) ||
		(nxt_state == bcs_pkg::BCS_CHARGE) || (nxt_state == bcs_pkg::BCS_TOPOFF));
	assign tmr_val = (nxt_state == bcs_pkg::BCS_CHARGE) ? bcs_pkg::CHARGE_TICKS
		: bcs_pkg::PREQ_TICKS;

	// Next state; loss of power or enable high overrides everything
	always_comb begin
		nxt_state = state_ff;
		if (!pwr_ok || en_n) begin
			nxt_state = bcs_pkg::BCS_DISABLE;
		end else begin
			case (state_ff)
				bcs_pkg::BCS_DISABLE: begin
					nxt_state = bcs_pkg::BCS_PREQUAL;
				end
				bcs_pkg::BCS_PREQUAL: begin
					if (!thm_ok)
						nxt_state = bcs_pkg::BCS_THM_HOLD;
					else if (bat_3v)
						nxt_state = bcs_pkg::BCS_CHARGE;
					else if (tmr_exp)
						nxt_state = bcs_pkg::BCS_FAULT;
				end
				bcs_pkg::BCS_CHARGE: begin
					if (!thm_ok)
						nxt_state = bcs_pkg::BCS_THM_HOLD;
					else if (cur_low)
						nxt_state = bcs_pkg::BCS_TOPOFF;
					else if (tmr_exp)
						nxt_state = bcs_pkg::BCS_FAULT;
				end
				bcs_pkg::BCS_TOPOFF: begin
					if (tmr_exp)
						nxt_state = bcs_pkg::BCS_DONE;
				end
				bcs_pkg::BCS_DONE: begin
					if (bat_low)
						nxt_state = bcs_pkg::BCS_CHARGE;
				end
				bcs_pkg::BCS_THM_HOLD: begin
					if (thm_ok)
						nxt_state = hold_ret_ff;
				end
				bcs_pkg::BCS_FAULT: begin
					nxt_state = bcs_pkg::BCS_FAULT;
				end
				default: begin
					nxt_state = bcs_pkg::BCS_DISABLE;
				end
			endcase
		end
	end

	// Charging flag: low in Charge, high elsewhere, held through hold
	always_comb begin
		case (nxt_state)
			bcs_pkg::BCS_CHARGE:   nxt_chg_n = 1'b0;
			bcs_pkg::BCS_THM_HOLD: nxt_chg_n = chg_n_ff;
			default:               nxt_chg_n = 1'b1;
		endcase
	end

	// Fault flag is sticky; only Disable (power or enable cycle) clears it
	assign nxt_flt_n = (nxt_state == bcs_pkg::BCS_FAULT) ? 1'b0
		: (nxt_state == bcs_pkg::BCS_DISABLE) ? 1'b1 : flt_n_ff;

	// Current command for the regulator
	always_comb begin
		case (nxt_state)
			bcs_pkg::BCS_PREQUAL: nxt_cur = bcs_pkg::CUR_SET_PREQ;
			bcs_pkg::BCS_TOPOFF:  nxt_cur = bcs_pkg::CUR_SET_TOPOFF;
			bcs_pkg::BCS_CHARGE: begin
				if (use_dc)
					nxt_cur = bcs_pkg::CUR_SET_FULL;
				else
					nxt_cur = usb_hi ? bcs_pkg::CUR_USB_475MA : bcs_pkg::CUR_USB_95MA;
			end
			default:              nxt_cur = bcs_pkg::CUR_OFF;
		endcase
	end

	// State register and return point for thermistor hold
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff    <= bcs_pkg::BCS_DISABLE;
			hold_ret_ff <= bcs_pkg::BCS_PREQUAL;
			tick_d_ff   <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			tick_d_ff <= tick_lvl;
			if (nxt_state == bcs_pkg::BCS_THM_HOLD && !in_hold)
				hold_ret_ff <= state_ff;
		end
	end

	// Output flops
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pok_n_ff   <= 1'b1;
			chg_n_ff   <= 1'b1;
			flt_n_ff   <= 1'b1;
			dc_sel_ff  <= 1'b0;
			usb_sel_ff <= 1'b0;
			cur_ff     <= bcs_pkg::CUR_OFF;
		end else begin
			pok_n_ff   <= !pwr_ok;
			chg_n_ff   <= nxt_chg_n;
			flt_n_ff   <= nxt_flt_n;
			dc_sel_ff  <= use_dc;
			usb_sel_ff <= use_usb;
			cur_ff     <= nxt_cur;
		end
	end

	assign power_good_flag_n_o = pok_n_ff;
	assign charging_flag_n_o   = chg_n_ff;
	assign fault_flag_n_o      = flt_n_ff;
	assign src_dc_sel_o        = dc_sel_ff;
	assign src_usb_sel_o       = usb_sel_ff;
	assign current_cmd_o       = cur_ff;
	assign state_o             = state_ff;

	// Checks on enable, source choice, input validity and the power flag
	enable_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		en_n
		|=> state_ff == bcs_pkg::BCS_DISABLE) else $error("enable high not disabled");
	dc_priority_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		dc_ok
		|=> dc_sel_ff && !usb_sel_ff) else $error("dc not preferred");
	usb_source_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		usb_ok && !dc_ok
		|=> usb_sel_ff && !dc_sel_ff) else $error("usb not chosen alone");
	dc_ov_block_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		dc_win && dc_ov
		|=> !dc_sel_ff) else $error("dc used above overvoltage");
	usb_ov_block_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		usb_win && usb_ov
		|=> !usb_sel_ff) else $error("usb used above overvoltage");
	pok_level_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		pok_n_ff == !$past(pwr_ok)) else $error("power good wrong");
	power_loss_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!pwr_ok
		|=> state_ff == bcs_pkg::BCS_DISABLE && pok_n_ff) else $error("no disable on power loss");

	// Checks on the charging and fault flags
	chg_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_ff == bcs_pkg::BCS_CHARGE
		|-> !chg_n_ff) else $error("charge flag high in charge");
	chg_flag_high_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_ff == bcs_pkg::BCS_PREQUAL || state_ff == bcs_pkg::BCS_TOPOFF
		|-> chg_n_ff) else $error("charge flag low outside charge");
	hold_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		in_hold && $past(in_hold)
		|-> $stable(chg_n_ff)) else $error("flag moved in hold");
	hold_entry_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$rose(in_hold)
		|-> chg_n_ff == $past(chg_n_ff)) else $error("flag moved on hold entry");
	fault_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_ff == bcs_pkg::BCS_FAULT
		|-> !flt_n_ff) else $error("fault flag high in fault");
	fault_latch_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!flt_n_ff && !en_n && pwr_ok
		|=> !flt_n_ff) else $error("fault released");
	fault_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		en_n
		|=> flt_n_ff) else $error("fault kept after enable cycle");

	// Checks on the state sequence; each antecedent also names power and enable,
	// since either of them overrides every other transition
	start_prequal_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_ff == bcs_pkg::BCS_DISABLE && pwr_ok && !en_n
		|=> state_ff == bcs_pkg::BCS_PREQUAL) else $error("no start into prequal");
	preq_charge_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_ff == bcs_pkg::BCS_PREQUAL && thm_ok && bat_3v && pwr_ok && !en_n
		|=> state_ff == bcs_pkg::BCS_CHARGE) else $error("no charge at 3 volt");
	preq_fault_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_ff == bcs_pkg::BCS_PREQUAL && tmr_exp && thm_ok && !bat_3v && pwr_ok && !en_n
		|=> state_ff == bcs_pkg::BCS_FAULT && !flt_n_ff) else $error("no prequal fault");
	preq_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_ff == bcs_pkg::BCS_PREQUAL && !thm_ok && pwr_ok && !en_n
		|=> in_hold) else $error("no thermistor hold in prequal");
	thm_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_ff == bcs_pkg::BCS_CHARGE && !thm_ok && pwr_ok && !en_n
		|=> in_hold) else $error("no thermistor hold");
	hold_resume_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		in_hold && thm_ok && pwr_ok && !en_n
		|=> state_ff == $past(hold_ret_ff)) else $error("hold left to wrong state");
	topoff_entry_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_ff == bcs_pkg::BCS_CHARGE && thm_ok && cur_low && pwr_ok && !en_n
		|=> state_ff == bcs_pkg::BCS_TOPOFF) else $error("no top-off at low current");
	topoff_done_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_ff == bcs_pkg::BCS_TOPOFF && tmr_exp && pwr_ok && !en_n
		|=> state_ff == bcs_pkg::BCS_DONE) else $error("no done after top-off");
	done_recharge_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_ff == bcs_pkg::BCS_DONE && bat_low && pwr_ok && !en_n
		|=> state_ff == bcs_pkg::BCS_CHARGE && !chg_n_ff) else $error("no recharge from done");

	// Checks on the state timer
	hold_freeze_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		in_hold
		|-> !tmr_load) else $error("timer reloaded in hold");
	timer_reload_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$changed(state_ff) && $past(state_ff) != bcs_pkg::BCS_THM_HOLD && state_ff inside
		{bcs_pkg::BCS_PREQUAL, bcs_pkg::BCS_CHARGE, bcs_pkg::BCS_TOPOFF}
		|-> $past(tmr_load)) else $error("timer not reloaded on entry");

	// Checks on the regulator current command
	preq_cur_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_ff == bcs_pkg::BCS_PREQUAL
		|-> cur_ff == bcs_pkg::CUR_SET_PREQ) else $error("prequal current wrong");
	topoff_cur_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_ff == bcs_pkg::BCS_TOPOFF
		|-> cur_ff == bcs_pkg::CUR_SET_TOPOFF) else $error("top-off current wrong");
	dc_cur_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_ff == bcs_pkg::BCS_CHARGE && dc_sel_ff
		|-> cur_ff == bcs_pkg::CUR_SET_FULL) else $error("dc charge current wrong");
	usb_cur_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_ff == bcs_pkg::BCS_CHARGE && usb_sel_ff && $past(usb_hi)
		|-> cur_ff == bcs_pkg::CUR_USB_475MA) else $error("usb current wrong");
	usb_low_cur_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_ff == bcs_pkg::BCS_CHARGE && usb_sel_ff && !$past(usb_hi)
		|-> cur_ff == bcs_pkg::CUR_USB_95MA) else $error("usb low current wrong");
	done_cur_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		state_ff == bcs_pkg::BCS_DONE
		|-> cur_ff == bcs_pkg::CUR_OFF) else $error("current in done");

	// Main scenarios worth seeing at least once
	reach_charge_c: cover property (@(posedge ref_clk_i) state_ff == bcs_pkg::BCS_CHARGE);
	reach_done_c:   cover property (@(posedge ref_clk_i) state_ff == bcs_pkg::BCS_DONE);
	reach_fault_c:  cover property (@(posedge ref_clk_i) state_ff == bcs_pkg::BCS_FAULT);
	hold_back_c:    cover property (@(posedge ref_clk_i) in_hold ##1 !in_hold);
	usb_charge_c:   cover property (@(posedge ref_clk_i) state_ff == bcs_pkg::BCS_CHARGE && usb_sel_ff);
endmodule : bcs_top
`default_nettype wire

// >>> tb/bcs_cell_model.sv
// Battery cell, thermistor and timing oscillator facing the sequencer
`default_nettype none
module bcs_cell_model (
	// Clock
	input  wire logic        ref_clk_i,
	// Scenario settings
	input  wire logic [15:0] bat_mv_i,
	input  wire logic [15:0] thm_ohm_i,
	input  wire logic [9:0]  cur_pm_i,
	input  wire logic        tick_run_i,
	// Comparator levels
	output logic             bat_above_3v_o,
	output logic             bat_below_4v05_o,
	output logic             cur_below_topoff_o,
	output logic [1:0]       thm_zone_o,
	output logic             tick_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] div_ff = 2'h0;

	// Cell voltage and current comparators: 3 V, 4.05 V and 75 per mille of 1000
	assign bat_above_3v_o     = bat_mv_i >= 16'h0BB8;
	assign bat_below_4v05_o   = bat_mv_i < 16'h0FD2;
	assign cur_below_topoff_o = cur_pm_i <= 10'h04B;

	// Thermistor zones at 315, 3940 and 28300 ohm
	assign thm_zone_o = (thm_ohm_i < 16'h013B) ? bcs_pkg::THM_ZONE_NONE :
		(thm_ohm_i < 16'h0F64) ? bcs_pkg::THM_ZONE_HOT :
		(thm_ohm_i <= 16'h6E8C) ? bcs_pkg::THM_ZONE_OK : bcs_pkg::THM_ZONE_COLD;

	// Oscillator stands still unless run; one rising edge per four clocks
	always_ff @(posedge ref_clk_i) begin
		if (tick_run_i) begin
			div_ff <= div_ff + 2'h1;
		end
	end
	assign tick_o = div_ff[1];
endmodule : bcs_cell_model
`default_nettype wire

// >>> tb/bcs_top_test.sv
// Self-checking bench for the battery charge sequencer
`default_nettype none
module bcs_top_test;
	timeunit 1ns;
	timeprecision 1ps;

	// Stimulus, all set at time zero
	logic        ref_clk_i            = 1'b0;
	logic        rst_i                = 1'b1;
	logic        dc_in_window_i       = 1'b0;
	logic        dc_over_volt_i       = 1'b0;
	logic        usb_in_window_i      = 1'b0;
	logic        usb_over_volt_i      = 1'b0;
	logic        enable_n_i           = 1'b1;
	logic        usb_current_select_i = 1'b0;
	logic [15:0] bat_mv               = 16'h09C4; // 2.5 V
	logic [15:0] thm_ohm              = 16'h2710; // 10k, valid zone
	logic [9:0]  cur_pm               = 10'h3E8; // Full current
	logic        tick_run             = 1'b0;
	// Model and design outputs
	logic        bat_above_3v_i, bat_below_4v05_i, cur_below_topoff_i, timer_capacitor_tick_i;
	logic [1:0]  thermistor_zone_i;
	logic        power_good_flag_n_o, charging_flag_n_o, fault_flag_n_o, src_dc_sel_o, src_usb_sel_o;
	logic [2:0]  current_cmd_o, state_o;
	int          num_errors = 0;
	int          num_checks = 0;
	wire logic [2:0] flags = {power_good_flag_n_o, charging_flag_n_o, fault_flag_n_o};

	always #5 ref_clk_i = ~ref_clk_i;

	bcs_top bcs_top_i (
		.ref_clk_i, .rst_i, .dc_in_window_i, .dc_over_volt_i, .usb_in_window_i, .usb_over_volt_i,
		.enable_n_i, .usb_current_select_i, .bat_above_3v_i, .bat_below_4v05_i, .cur_below_topoff_i,
		.thermistor_zone_i, .timer_capacitor_tick_i, .power_good_flag_n_o, .charging_flag_n_o,
		.fault_flag_n_o, .src_dc_sel_o, .src_usb_sel_o, .current_cmd_o, .state_o
	);

	bcs_cell_model bcs_cell_model_i (
		.ref_clk_i, .bat_mv_i(bat_mv), .thm_ohm_i(thm_ohm), .cur_pm_i(cur_pm), .tick_run_i(tick_run),
		.bat_above_3v_o(bat_above_3v_i), .bat_below_4v05_o(bat_below_4v05_i),
		.cur_below_topoff_o(cur_below_topoff_i), .thm_zone_o(thermistor_zone_i),
		.tick_o(timer_capacitor_tick_i)
	);

	// Inputs always move 1 ns after a rising edge
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : step

	// Let the oscillator run for about n ticks
	task automatic ticks(input int n);
		tick_run = 1'b1;
		step(4 * n);
		tick_run = 1'b0;
		step(2);
	endtask : ticks

	task automatic chk(input logic [2:0] got, input logic [2:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t ns: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : stop_test

	// Watchdog: the sequence needs about 20k cycles
	initial begin
		#400000;
		num_errors++;
		stop_test();
	end

	// Main sequence; answers land 3 edges after a change, 5 are allowed
	initial begin
		step(4);
		rst_i = 1'b0;
		step(2);
		chk(state_o, bcs_pkg::BCS_DISABLE);
		chk(flags, 3'h7);
		dc_in_window_i = 1'b1;
		step(5);
		chk(state_o, bcs_pkg::BCS_DISABLE);
		chk(flags, 3'h3);
		enable_n_i = 1'b0;
		step(5);
		chk(state_o, bcs_pkg::BCS_PREQUAL);
		chk(current_cmd_o, bcs_pkg::CUR_SET_PREQ);
		chk(flags, 3'h3);
		// Hot cell near the end of prequal must freeze, not fault
		ticks(int'(bcs_pkg::PREQ_TICKS) - 100);
		thm_ohm = 16'h07D0;
		step(5);
		chk(state_o, bcs_pkg::BCS_THM_HOLD);
		chk(flags, 3'h3);
		ticks(500);
		thm_ohm = 16'h2710;
		step(5);
		chk(state_o, bcs_pkg::BCS_PREQUAL);
		ticks(150);
		chk(state_o, bcs_pkg::BCS_FAULT);
		chk({2'h0, fault_flag_n_o}, 3'h0);
		// Fault stays latched until enable is cycled
		bat_mv = 16'h0DAC; // 3.5 V
		step(5);
		chk(state_o, bcs_pkg::BCS_FAULT);
		enable_n_i = 1'b1;
		step(5);
		chk(state_o, bcs_pkg::BCS_DISABLE);
		chk({2'h0, fault_flag_n_o}, 3'h1);
		enable_n_i = 1'b0;
		step(6);
		chk(state_o, bcs_pkg::BCS_CHARGE);
		chk(current_cmd_o, bcs_pkg::CUR_SET_FULL);
		chk(flags, 3'h1);
		thm_ohm = 16'h9C40;
		step(5);
		chk(state_o, bcs_pkg::BCS_THM_HOLD);
		chk(flags, 3'h1);
		thm_ohm = 16'h0064;
		step(5);
		chk(state_o, bcs_pkg::BCS_CHARGE);
		// Source choice and USB current levels
		usb_in_window_i = 1'b1;
		usb_current_select_i = 1'b1;
		step(5);
		chk({1'b0, src_dc_sel_o, src_usb_sel_o}, 3'h2);
		chk(current_cmd_o, bcs_pkg::CUR_SET_FULL);
		dc_in_window_i = 1'b0;
		step(5);
		chk({1'b0, src_dc_sel_o, src_usb_sel_o}, 3'h1);
		chk(current_cmd_o, bcs_pkg::CUR_USB_475MA);
		usb_current_select_i = 1'b0;
		step(5);
		chk(current_cmd_o, bcs_pkg::CUR_USB_95MA);
		dc_in_window_i = 1'b1;
		// Top-off, its timer, done and recharge
		bat_mv = 16'h1004; // 4.1 V
		cur_pm = 10'h032;
		step(5);
		chk(state_o, bcs_pkg::BCS_TOPOFF);
		chk(current_cmd_o, bcs_pkg::CUR_SET_TOPOFF);
		chk(flags, 3'h3);
		ticks(int'(bcs_pkg::PREQ_TICKS) - 50);
		chk(state_o, bcs_pkg::BCS_TOPOFF);
		ticks(100);
		chk(state_o, bcs_pkg::BCS_DONE);
		chk(current_cmd_o, bcs_pkg::CUR_OFF);
		cur_pm = 10'h3E8;
		bat_mv = 16'h0FA0; // 4.0 V
		step(5);
		chk(state_o, bcs_pkg::BCS_CHARGE);
		// Overvoltage on the only input blocks charging
		usb_in_window_i = 1'b0;
		dc_over_volt_i = 1'b1;
		step(5);
		chk(state_o, bcs_pkg::BCS_DISABLE);
		chk(flags, 3'h7);
		// USB alone charges while DC is over voltage, then its own overvoltage blocks it
		usb_in_window_i = 1'b1;
		step(6);
		chk(state_o, bcs_pkg::BCS_CHARGE);
		chk({1'b0, src_dc_sel_o, src_usb_sel_o}, 3'h1);
		chk(current_cmd_o, bcs_pkg::CUR_USB_95MA);
		usb_over_volt_i = 1'b1;
		step(5);
		chk(state_o, bcs_pkg::BCS_DISABLE);
		chk(flags, 3'h7);
		stop_test();
	end
endmodule : bcs_top_test
`default_nettype wire
